// ===== hdl/startup_cfg.svh
// constants for the startup and run/stop controller
`ifndef STARTUP_CFG_SVH
`define STARTUP_CFG_SVH
`define N_IN        8
`define N_OUT       4
`define N_EXP       4
`define CYCLE_NS    20000
`define CLK_NS      50
`define CYCLE_CLKS  ((`CYCLE_NS + `CLK_NS - 1) / `CLK_NS)
`define INIT_NS     1000
`define INIT_CLKS   ((`INIT_NS + `CLK_NS - 1) / `CLK_NS)
`define SETTLE_CLKS 2
`endif

// ===== hdl/startup_pkg.sv
// types shared by the startup and run/stop controller
package startup_pkg;
  typedef enum logic [1:0] {led_off, led_red, led_green, led_orange} led_t;
  typedef enum logic [1:0] {msg_none, msg_no_program, msg_io_monitor,
                            msg_programming} msg_t;
  typedef enum logic [1:0] {copy_idle, copy_req, copy_wait} copy_st_t;
  typedef struct packed {
    logic present;
    logic has_prog;
    logic copy_done;
  } card_t;
  typedef struct packed {
    logic has_prog;
    logic last_run;
    logic entry_open;
  } store_t;
endpackage

// ===== hdl/startup_run_stop.sv
// power-up sequencing and STOP/RUN control of the logic module
`timescale 1ns/1ns
`include "startup_cfg.svh"

// How it works
// [R1] no program: show no-program, await escape
// [R2] card program copied over internal storage
// [R3] resume state held at power loss
// [R4] display-less units go STOP to RUN
// [R5] retentive values kept across power loss
// [R6] half-entered program discarded on power-up
// [R7] exactly one of STOP or RUN
// [R8] STOP does not sample inputs
// [R9] STOP does not evaluate program
// [R10] STOP forces all outputs off
// [R11] RUN samples inputs every cycle
// [R12] RUN computes and drives outputs
// [R13] program mode from STOP, params from RUN
// [R14] led red in STOP, green in RUN; code drives it on display-less units only, off with a display
// [R15] expansion led green, red, orange
// [R16] display-less never writes the card
// [R17] display-less program loaded from outside
// [R18] card copy finished before state choice
// [R19] inputs stable one cycle, fast exempt
module startup_run_stop (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   has_display,
  input  wire startup_pkg::card_t     card,
  input  wire startup_pkg::store_t    store,
  input  wire logic                   key_esc,
  input  wire logic                   cmd_start,
  input  wire logic                   cmd_stop,
  input  wire logic                   cmd_prog_mode,
  input  wire logic                   cmd_param_mode,
  input  wire logic                   cmd_leave_mode,
  input  wire logic [`N_IN-1:0]       in_pins,
  input  wire logic [`N_OUT-1:0]      prog_result,
  input  wire logic [`N_EXP-1:0]      exp_link_ok,
  input  wire logic [`N_EXP-1:0]      exp_init,
  output logic                        copy_req_q,
  output logic                        card_write_en_q,
  output logic                        discard_entry_q,
  output logic                        retain_keep_q,
  output logic                        run_q,
  output logic                        eval_en_q,
  output logic [`N_IN-1:0]            in_image_q,
  output logic [`N_OUT-1:0]           out_q,
  output startup_pkg::led_t           status_led_q,
  output startup_pkg::msg_t           msg_q,
  output logic                        prog_mode_q,
  output logic                        param_mode_q,
  output startup_pkg::led_t [`N_EXP-1:0] exp_led_q,
  output logic                        ready_q
);

  // ==========================================================
  // input synchronisers
  // ==========================================================
  logic [`N_IN-1:0]  in_s1_q;
  logic [`N_IN-1:0]  in_s2_q;
  logic [`N_EXP-1:0] ok_s1_q;
  logic [`N_EXP-1:0] ok_s2_q;
  logic [`N_EXP-1:0] ini_s1_q;
  logic [`N_EXP-1:0] ini_s2_q;
  logic [2:0]        card_s1_q;
  logic [2:0]        card_s2_q;
  logic              esc_s1_q;
  logic              esc_s2_q;

  // pins and card lines come from outside the clock domain
  always_ff @(posedge clk) begin
    if (rst) begin
      in_s1_q   <= '0;
      in_s2_q   <= '0;
      ok_s1_q   <= '0;
      ok_s2_q   <= '0;
      ini_s1_q  <= '0;
      ini_s2_q  <= '0;
      card_s1_q <= 3'h0;
      card_s2_q <= 3'h0;
      esc_s1_q  <= 1'b0;
      esc_s2_q  <= 1'b0;
    end else begin
      in_s1_q   <= in_pins;
      in_s2_q   <= in_s1_q;
      ok_s1_q   <= exp_link_ok;
      ok_s2_q   <= ok_s1_q;
      ini_s1_q  <= exp_init;
      ini_s2_q  <= ini_s1_q;
      card_s1_q <= card;
      card_s2_q <= card_s1_q;
      esc_s1_q  <= key_esc;
      esc_s2_q  <= esc_s1_q;
    end
  end

  startup_pkg::card_t card_s;
  assign card_s = card_s2_q;

  // ==========================================================
  // power-up sequence
  // ==========================================================
  typedef enum logic [2:0] {
    st_check, st_copy, st_no_prog, st_decide, st_operate
  } boot_t;

  boot_t                 boot_q;
  startup_pkg::copy_st_t copy_q;
  logic                  int_prog_q;
  logic [1:0]            settle_q;
  logic                  settle_done;

  // card lines cross two flops; reading them earlier sees reset zeros
  assign settle_done = (settle_q == 2'(`SETTLE_CLKS));

  always_ff @(posedge clk) begin
    if (rst) begin
      boot_q     <= st_check;
      copy_q     <= startup_pkg::copy_idle;
      copy_req_q <= 1'b0;
      int_prog_q <= 1'b0;
      settle_q   <= 2'h0;
    end else begin
      unique case (boot_q)
        st_check: begin
          if (!settle_done) begin
            settle_q <= settle_q + 2'h1;
          end else begin
            // [R6] drop partial entry
            int_prog_q <= store.has_prog & ~store.entry_open;
            // [R18] card before state choice
            if (card_s.present && card_s.has_prog) begin
              boot_q     <= st_copy;
              copy_q     <= startup_pkg::copy_req;
              copy_req_q <= 1'b1;
            end else if (store.has_prog && !store.entry_open) begin
              boot_q <= st_decide;
            end else begin
              boot_q <= st_no_prog;
            end
          end
        end
        st_copy: begin
          // [R2] card overwrites storage
          copy_q <= startup_pkg::copy_wait;
          if (card_s.copy_done) begin
            copy_req_q <= 1'b0;
            copy_q     <= startup_pkg::copy_idle;
            int_prog_q <= 1'b1;
            boot_q     <= st_decide;
          end
        end
        st_no_prog: begin
          // [R1] wait for escape; card may arrive later
          if (card_s.present && card_s.has_prog) begin
            boot_q     <= st_copy;
            copy_q     <= startup_pkg::copy_req;
            copy_req_q <= 1'b1;
          end else if (esc_s2_q) begin
            boot_q <= st_operate;
          end
        end
        st_decide: boot_q <= st_operate;
        st_operate: boot_q <= st_operate;
        default: boot_q <= st_check;
      endcase
    end
  end

  // ==========================================================
  // STOP/RUN state
  // ==========================================================
  // [R7] single run flag: exactly one state
  always_ff @(posedge clk) begin
    if (rst) begin
      run_q <= 1'b0;
    end else if (boot_q == st_decide) begin
      // [R3] resume saved state; [R4] display-less runs
      run_q <= has_display ? store.last_run : 1'b1;
    end else if (boot_q == st_operate && int_prog_q) begin
      if (cmd_stop || prog_mode_q) begin
        run_q <= 1'b0;
      // a start never lands on the edge that opens programming
      end else if (cmd_start && !param_mode_q && !cmd_prog_mode) begin
        run_q <= 1'b1;
      end
    end else begin
      run_q <= 1'b0;
    end
  end

  // [R13] mode entry gated by state
  always_ff @(posedge clk) begin
    if (rst) begin
      prog_mode_q  <= 1'b0;
      param_mode_q <= 1'b0;
    end else if (!has_display || boot_q != st_operate || cmd_leave_mode) begin
      prog_mode_q  <= 1'b0;
      param_mode_q <= 1'b0;
    end else begin
      if (cmd_prog_mode && !run_q && !param_mode_q) begin
        prog_mode_q <= 1'b1;
      end
      if (cmd_param_mode && run_q && !prog_mode_q && !cmd_stop) begin
        param_mode_q <= 1'b1;
      end
      if (!run_q) begin
        param_mode_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // program cycle: sample, evaluate, drive
  // ==========================================================
  // cycle length is fixed; real scan time varies with program size
  logic [$clog2(`CYCLE_CLKS)-1:0] cyc_q;
  logic                           cyc_end;
  assign cyc_end = (cyc_q == ($clog2(`CYCLE_CLKS))'(`CYCLE_CLKS - 1));

  always_ff @(posedge clk) begin
    if (rst || !run_q || cyc_end) begin
      cyc_q <= '0;
    end else begin
      cyc_q <= cyc_q + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || !run_q) begin
      // [R8] no sampling in STOP
      in_image_q <= '0;
      // [R9] no evaluation in STOP
      eval_en_q  <= 1'b0;
    end else begin
      // [R11] sample once per cycle; [R19] needs cycle-long levels
      if (cyc_q == '0) begin
        in_image_q <= in_s2_q;
      end
      eval_en_q <= (cyc_q == ($clog2(`CYCLE_CLKS))'(1));
    end
  end

  always_ff @(posedge clk) begin
    if (rst || !run_q) begin
      // [R10] outputs off in STOP
      out_q <= '0;
    end else if (cyc_end) begin
      // [R12] drive evaluated outputs
      out_q <= prog_result;
    end
  end

  // ==========================================================
  // indicators, messages, card and retention
  // ==========================================================
  always_ff @(posedge clk) begin
    if (rst) begin
      status_led_q <= startup_pkg::led_off;
      msg_q        <= startup_pkg::msg_none;
    end else begin
      // [R14] display-less: red STOP, green RUN; off with display
      if (has_display) begin
        status_led_q <= startup_pkg::led_off;
      end else begin
        status_led_q <= run_q ? startup_pkg::led_green : startup_pkg::led_red;
      end
      // [R1] no-program message
      if (!has_display) begin
        msg_q <= startup_pkg::msg_none;
      end else if (boot_q == st_no_prog) begin
        msg_q <= startup_pkg::msg_no_program;
      end else if (prog_mode_q) begin
        msg_q <= startup_pkg::msg_programming;
      end else if (run_q) begin
        // [R13] monitoring screen in RUN
        msg_q <= startup_pkg::msg_io_monitor;
      end else begin
        msg_q <= startup_pkg::msg_none;
      end
    end
  end

  // [R15] expansion indicators, init wins
  genvar g;
  generate
    for (g = 0; g < `N_EXP; g++) begin : g_exp
      always_ff @(posedge clk) begin
        if (rst) begin
          exp_led_q[g] <= startup_pkg::led_orange;
        end else if (ini_s2_q[g]) begin
          exp_led_q[g] <= startup_pkg::led_orange;
        end else if (ok_s2_q[g]) begin
          exp_led_q[g] <= startup_pkg::led_green;
        end else begin
          exp_led_q[g] <= startup_pkg::led_red;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst) begin
      card_write_en_q <= 1'b0;
      discard_entry_q <= 1'b0;
      retain_keep_q   <= 1'b1;
      ready_q         <= 1'b0;
    end else begin
      // [R16] display-less never writes card
      card_write_en_q <= has_display & prog_mode_q & card_s.present;
      // [R6] discard partial entry
      discard_entry_q <= (boot_q == st_check) & settle_done & store.entry_open;
      // [R5] retentive values kept
      retain_keep_q   <= 1'b1;
      // [R17] program loaded from outside
      ready_q         <= (boot_q == st_operate) & int_prog_q;
    end
  end

endmodule // startup_run_stop

// ===== verification/startup_run_stop_assertions.sv
// checker for the startup and run/stop controller
`timescale 1ns/1ns
`include "startup_cfg.svh"
// =====================================
// port watcher
module startup_run_stop_assertions (
  input wire logic               clk,
  input wire logic               rst,
  input wire logic               has_display,
  input wire logic               run_q,
  input wire logic               eval_en_q,
  input wire logic               copy_req_q,
  input wire logic               card_write_en_q,
  input wire logic               prog_mode_q,
  input wire logic               param_mode_q,
  input wire logic [`N_IN-1:0]   in_image_q,
  input wire logic [`N_OUT-1:0]  out_q,
  input wire startup_pkg::led_t  status_led_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_stop_outs_off: assert property (!run_q |=> out_q == '0)
    else $error("outputs driven in stop");
  a_stop_no_sample: assert property (!run_q |=> in_image_q == '0)
    else $error("inputs sampled in stop");
  a_stop_no_eval: assert property (!run_q |=> !eval_en_q)
    else $error("program evaluated in stop");
  a_eval_one_shot: assert property (eval_en_q |=> !eval_en_q [*8])
    else $error("evaluation pulse repeated");
  a_prog_in_stop: assert property (prog_mode_q |-> !run_q)
    else $error("programming mode while running");
  a_param_from_run: assert property ($rose(param_mode_q) |-> $past(run_q))
    else $error("parameter mode entered from stop");
  a_led_green_run: assert property (
    !has_display && run_q [*2] |-> status_led_q == startup_pkg::led_green)
    else $error("status led not green in run");
  a_no_card_write: assert property (!has_display |-> !card_write_en_q)
    else $error("display-less unit may write card");
  // a running unit never starts a copy; copy ends before state is chosen
  a_copy_before_run: assert property (copy_req_q |-> !run_q)
    else $error("running while card copy pending");
endmodule // startup_run_stop_assertions

// ===== verification/card_model.sv
// program card model for the startup and run/stop controller
`timescale 1ns/1ns
// =====================================
// card
module card_model (
  input  wire logic          clk,
  input  wire logic          present,
  input  wire logic [3:0]    lag,
  input  wire logic          copy_req_q,
  output startup_pkg::card_t card
);
  logic [3:0] cnt_q;
  // copy takes lag clocks; lag sets prompt or slow
  always_ff @(posedge clk) begin
    if (!copy_req_q) cnt_q <= 4'h0;
    else if (cnt_q != lag) cnt_q <= cnt_q + 4'h1;
  end
  assign card = '{present, present, copy_req_q && cnt_q == lag};
endmodule // card_model

// ===== verification/startup_run_stop_bench.sv
// bench for the startup and run/stop controller
`timescale 1ns/1ns
`include "startup_cfg.svh"
// =====================================
// bench
module startup_run_stop_bench;
  logic clk, rst, has_display, key_esc, cmd_start, cmd_stop;
  logic cmd_prog_mode, cmd_param_mode, cmd_leave_mode, c_in;
  logic copy_req_q, card_write_en_q, discard_entry_q, retain_keep_q;
  logic run_q, eval_en_q, prog_mode_q, param_mode_q, ready_q, seen, seen_cp;
  logic [3:0]                         lag;
  logic [`N_IN-1:0]                   in_pins, in_image_q;
  logic [`N_OUT-1:0]                  prog_result, out_q;
  logic [`N_EXP-1:0]                  exp_link_ok, exp_init;
  startup_pkg::card_t                 card;
  startup_pkg::store_t                store;
  startup_pkg::led_t                  status_led_q;
  startup_pkg::msg_t                  msg_q;
  startup_pkg::led_t [`N_EXP-1:0]     exp_led_q;
  int                                 fail_count, checks_done, n;
  startup_run_stop uut (.*);
  card_model cm (.clk(clk), .present(c_in), .lag(lag),
    .copy_req_q(copy_req_q), .card(card));
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  task wrap_up;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(string nm, logic [7:0] got, logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // a bound that runs out ends the run
  task guard(int lim);
    if (n >= lim) begin
      fail_count++;
      $display("BAD wait expected done seen timeout");
      wrap_up;
    end
  endtask
  task boot(logic d, cp, sp, lr, eo, logic [3:0] lg);
    rst = 1;
    has_display = d;
    c_in = cp;
    store = '{sp, lr, eo};
    lag = lg;
    repeat (5) @(negedge clk);
    rst = 0;
    seen = 0;
    seen_cp = 0;
    for (n = 0; n < 60 && ready_q !== 1'b1; n++) begin
      @(negedge clk);
      seen |= discard_entry_q;
      seen_cp |= copy_req_q;
    end
  endtask
  task t_noprog;
    boot(1, 0, 0, 0, 0, 0);
    chk("msg", msg_q, startup_pkg::msg_no_program);
    key_esc = 1;
    repeat (6) @(negedge clk);
    key_esc = 0;
    cmd_start = 1;
    @(negedge clk);
    cmd_start = 0;
    repeat (4) @(negedge clk);
    chk("run", run_q, 0);
    $display("no program test done");
  endtask
  task t_card;
    boot(1, 1, 1, 1, 0, 9);
    guard(60);
    chk("run", run_q, 1);
    chk("copy", copy_req_q, 0);
    chk("copied", seen_cp, 1);
    cmd_stop = 1;
    @(negedge clk);
    cmd_stop = 0;
    cmd_prog_mode = 1;
    @(negedge clk);
    cmd_prog_mode = 0;
    repeat (3) @(negedge clk);
    chk("prog", prog_mode_q, 1);
    chk("msg", msg_q, startup_pkg::msg_programming);
    chk("cardwr", card_write_en_q, 1);
    cmd_leave_mode = 1;
    @(negedge clk);
    cmd_leave_mode = 0;
    $display("card test done");
  endtask
  task t_run;
    boot(1, 1, 1, 1, 1, 0);
    guard(60);
    chk("discard", seen, 1);
    chk("copied", seen_cp, 1);
    chk("retain", retain_keep_q, 1);
    // inputs held over whole program cycles
    in_pins = 8'ha5;
    prog_result = 4'h9;
    for (n = 0; n < 900 && in_image_q !== 8'ha5; n++) @(negedge clk);
    guard(900);
    chk("image", in_image_q, 8'ha5);
    chk("out", out_q, 4'h9);
    chk("msg", msg_q, startup_pkg::msg_io_monitor);
    cmd_param_mode = 1;
    @(negedge clk);
    cmd_param_mode = 0;
    repeat (2) @(negedge clk);
    chk("param", param_mode_q, 1);
    cmd_stop = 1;
    @(negedge clk);
    cmd_stop = 0;
    repeat (3) @(negedge clk);
    chk("out", out_q, 0);
    chk("image", in_image_q, 0);
    chk("param", param_mode_q, 0);
    $display("run test done");
  endtask
  task t_nodisp;
    exp_init = 4'h1;
    exp_link_ok = 4'h2;
    boot(0, 0, 1, 0, 0, 0);
    guard(60);
    repeat (4) @(negedge clk);
    chk("run", run_q, 1);
    chk("led", status_led_q, startup_pkg::led_green);
    chk("exp", exp_led_q, {startup_pkg::led_red, startup_pkg::led_red,
      startup_pkg::led_green, startup_pkg::led_orange});
    $display("no display test done");
  endtask
  initial begin
    {rst, has_display, key_esc, cmd_start, cmd_stop, c_in} = 6'h20;
    {cmd_prog_mode, cmd_param_mode, cmd_leave_mode, lag} = 7'h00;
    store = '0;
    {in_pins, prog_result, exp_link_ok, exp_init} = 20'h00000;
    t_noprog;
    t_card;
    t_run;
    t_nodisp;
    wrap_up;
  end
endmodule // startup_run_stop_bench
bind startup_run_stop startup_run_stop_assertions chk_i (.*);
